// ---- rtl/pcc_top.sv ----
// Command word register with bus-enable and error-pin gating
// Function
// - Bits 15..11 read zero, ignore writes
// - Interrupt inhibit blocks INTx drive
// - Bit 9 reads zero, no back-to-back
// - SERR driver off while bit 8 clear
// - Address parity reported needs bits 8 and 6
// - Address parity error asserts SERR if bits 8 and 6 set
// - Data parity error asserts PERR if enabled
// - Bit 7 reads zero, ignores writes
// - Parity errors ignored while bit 6 clear
// - Snoop bit: capture, not claim, palette writes
// - Bit 4 hardwired zero, no invalidate writes
// - Bit 3 hardwired zero, no special cycles
// - Initiator requests only with bit 2 set
// - Memory claims only with bit 1 set
// - I/O claims only with bit 0 set
// - Interrupt needs pending and not inhibit
`timescale 1ns/1ps
module pcc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  input wire logic int_pending,
  input wire logic addr_par_err,
  input wire logic data_par_err,
  input wire logic mem_hit,
  input wire logic io_hit,
  input wire logic palette_wr,
  input wire logic init_req,
  output logic int_o,
  output logic int_oe,
  output logic serr_o,
  output logic serr_oe,
  output logic perr_o,
  output logic perr_oe,
  output logic claim,
  output logic snoop_capture,
  output logic init_grant_req,
  output pcc_pkg::pcc_word_t cmd_word
);
  import pcc_pkg::*;

  pcc_word_t cmd_q, cmd_d;
  logic [15:0] rd_q, rd_d;
  logic int_q, serr_q, perr_q, claim_q, snoop_q, req_q;
  logic int_n, serr_n, perr_n, claim_n, snoop_n, req_n;
  pcc_if cif ();

  // Merge enabled byte lanes, keep only writable bits
  function automatic pcc_word_t merge(input pcc_word_t old,
                                      input pcc_word_t wd,
                                      input logic [1:0] be);
    pcc_word_t m;
    m = {{8{be[1]}}, {8{be[0]}}} & CMD_WMASK;
    merge = (old & ~m) | (wd & m);
  endfunction

  // ----------------------------------------------------------------
  // Register next state
  // ----------------------------------------------------------------
  always_comb begin
    cmd_d = cmd_q;
    rd_d = rd_q;
    if (cfg_wr && cfg_addr == CMD_OFFSET) begin
      cmd_d = merge(cmd_q, cfg_wdata, cfg_be);
    end
    if (cfg_rd) begin
      rd_d = (cfg_addr == CMD_OFFSET) ? (cmd_q & CMD_WMASK) : 16'h0000;
    end
  end

  // Reset clears the whole word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_q <= CMD_RESET;
      rd_q <= 16'h0000;
    end else begin
      cmd_q <= cmd_d;
      rd_q <= rd_d;
    end
  end

  assign cif.cmd = cmd_q;

  pcc_gate u_gate (
    .c(cif),
    .int_pending(int_pending),
    .addr_par_err(addr_par_err),
    .data_par_err(data_par_err),
    .mem_hit(mem_hit),
    .io_hit(io_hit),
    .palette_wr(palette_wr),
    .init_req(init_req),
    .int_d(int_n),
    .serr_d(serr_n),
    .perr_d(perr_n),
    .claim_d(claim_n),
    .snoop_d(snoop_n),
    .req_d(req_n)
  );

  // ----------------------------------------------------------------
  // Pin registers; outputs leave straight from flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_q <= 1'b0;
      serr_q <= 1'b0;
      perr_q <= 1'b0;
      claim_q <= 1'b0;
      snoop_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      int_q <= int_n;
      serr_q <= serr_n;
      perr_q <= perr_n;
      claim_q <= claim_n;
      snoop_q <= snoop_n;
      req_q <= req_n;
    end
  end

  // Open-drain pins: low level driven only while asserted
  assign int_o = 1'b0;
  assign int_oe = int_q;
  assign serr_o = 1'b0;
  assign serr_oe = serr_q;
  assign perr_o = 1'b0;
  assign perr_oe = perr_q;
  assign claim = claim_q;
  assign snoop_capture = snoop_q;
  assign init_grant_req = req_q;
  assign cfg_rdata = rd_q;
  assign cmd_word = cmd_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_cmd_write;
    cfg_wr && cfg_addr == CMD_OFFSET;
  endsequence

  property p_hardwired;
    @(posedge clk) disable iff (!rst_n) (cmd_q & ~CMD_WMASK) == 16'h0000;
  endproperty
  a_hardwired: assert property (p_hardwired)
    else $error("hardwired command bits not zero");

  property p_b2b_zero;
    @(posedge clk) disable iff (!rst_n)
      cfg_rd |=> cfg_rdata[BIT_B2B] == 1'b0;
  endproperty
  a_b2b_zero: assert property (p_b2b_zero)
    else $error("back-to-back bit read nonzero");

  property p_int_gate;
    @(posedge clk) disable iff (!rst_n)
      cmd_q[BIT_INTOFF] && $stable(cmd_q) ##1 $stable(cmd_q) |-> !int_oe;
  endproperty
  a_int_gate: assert property (p_int_gate)
    else $error("interrupt driven while inhibited");

  property p_int_follow;
    @(posedge clk) disable iff (!rst_n)
      int_pending && !cmd_q[BIT_INTOFF] |=> int_oe;
  endproperty
  a_int_follow: assert property (p_int_follow)
    else $error("pending interrupt not driven");

  property p_serr;
    @(posedge clk) disable iff (!rst_n)
      addr_par_err && cmd_q[BIT_SYSERR] && cmd_q[BIT_PARITY] |=> serr_oe;
  endproperty
  a_serr: assert property (p_serr)
    else $error("address parity error not signalled");

  property p_serr_off;
    @(posedge clk) disable iff (!rst_n)
      serr_oe |-> $past(cmd_q[BIT_SYSERR]) && $past(cmd_q[BIT_PARITY]);
  endproperty
  a_serr_off: assert property (p_serr_off)
    else $error("system error driven while disabled");

  property p_perr;
    @(posedge clk) disable iff (!rst_n)
      data_par_err |=> perr_oe == $past(cmd_q[BIT_PARITY]);
  endproperty
  a_perr: assert property (p_perr)
    else $error("data parity response wrong");

  property p_claim;
    @(posedge clk) disable iff (!rst_n)
      claim |-> ($past(mem_hit) && $past(cmd_q[BIT_MEM])) ||
                ($past(io_hit) && $past(cmd_q[BIT_IO]));
  endproperty
  a_claim: assert property (p_claim)
    else $error("claim without space enable");

  property p_req;
    @(posedge clk) disable iff (!rst_n)
      init_grant_req |-> $past(cmd_q[BIT_INIT]);
  endproperty
  a_req: assert property (p_req)
    else $error("initiator request while disabled");

  // Snooped palette write is captured, never claimed
  property p_snoop;
    @(posedge clk) disable iff (!rst_n)
      palette_wr && cmd_q[BIT_SNOOP] |=> snoop_capture && !claim;
  endproperty
  a_snoop: assert property (p_snoop)
    else $error("snooped palette write claimed");

  property p_write;
    @(posedge clk) disable iff (!rst_n)
      s_cmd_write ##0 cfg_be == 2'b11 |=>
        cmd_q == ($past(cfg_wdata) & CMD_WMASK);
  endproperty
  a_write: assert property (p_write)
    else $error("command write not stored");
endmodule // pcc_top

// ---- rtl/pcc_pkg.sv ----
// Package: command word layout, offsets and reset value
package pcc_pkg;
  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // Bits that software may change; all others read zero
  localparam logic [15:0] CMD_WMASK = 16'h0567;
  localparam int BIT_IO = 0;
  localparam int BIT_MEM = 1;
  localparam int BIT_INIT = 2;
  localparam int BIT_SPECIAL = 3;
  localparam int BIT_WINV = 4;
  localparam int BIT_SNOOP = 5;
  localparam int BIT_PARITY = 6;
  localparam int BIT_RSVD7 = 7;
  localparam int BIT_SYSERR = 8;
  localparam int BIT_B2B = 9;
  localparam int BIT_INTOFF = 10;
  typedef logic [15:0] pcc_word_t;
endpackage

// ---- rtl/pcc_if.sv ----
// Interface: command bits handed from the register to the gating logic
`timescale 1ns/1ps
interface pcc_if;
  logic [15:0] cmd;
  modport src (output cmd);
  modport dst (input cmd);
endinterface

// ---- rtl/pcc_gate.sv ----
// Gate: combines command bits with card-side events
`timescale 1ns/1ps
module pcc_gate (
  pcc_if.dst c,
  input wire logic int_pending,
  input wire logic addr_par_err,
  input wire logic data_par_err,
  input wire logic mem_hit,
  input wire logic io_hit,
  input wire logic palette_wr,
  input wire logic init_req,
  output logic int_d,
  output logic serr_d,
  output logic perr_d,
  output logic claim_d,
  output logic snoop_d,
  output logic req_d
);
  import pcc_pkg::*;

  // Decode of enables
  always_comb begin
    int_d = int_pending & ~c.cmd[BIT_INTOFF];
    serr_d = addr_par_err & c.cmd[BIT_SYSERR] & c.cmd[BIT_PARITY];
    perr_d = data_par_err & c.cmd[BIT_PARITY];
    snoop_d = palette_wr & c.cmd[BIT_SNOOP];
    claim_d = ((mem_hit & c.cmd[BIT_MEM]) | (io_hit & c.cmd[BIT_IO]))
      & ~snoop_d;
    req_d = init_req & c.cmd[BIT_INIT];
  end
endmodule // pcc_gate

// ---- tb/pcc_host.sv ----
// Partner: configuration host that issues command word accesses
`timescale 1ns/1ps
module pcc_host (
  input wire logic clk,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [1:0] cfg_be,
  output logic [15:0] cfg_wdata
);
  // Bus idle at time zero
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 2'h0;
    cfg_wdata = 16'h0000;
  end
  // One access per edge; caller enters just after an edge
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [1:0] be, input logic [15:0] d);
    cfg_wr = w;
    cfg_rd = !w;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(posedge clk);
    #1;
  endtask
  // Strobes drop; address and data lines flip so stale values never look valid
  task automatic idle();
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = ~cfg_addr;
    cfg_wdata = ~cfg_wdata;
  endtask
endmodule // pcc_host

// ---- tb/tb.sv ----
// Testbench: command word register and pin gating
`timescale 1ns/1ps
module tb;
  import pcc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] ev = 7'h00;
  logic ev_v = 1'b0;
  logic ev_v_q = 1'b0;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic cfg_wr, cfg_rd;
  logic [7:0] cfg_addr;
  logic [1:0] cfg_be;
  logic [15:0] cfg_wdata, cfg_rdata, cmd_word, m;
  wire [8:0] pins;
  logic [31:0] seed = 32'd19441;
  logic [15:0] rq[$];
  logic [15:0] wq[$];
  logic [8:0] pq[$];
  int n_mismatch = 0;
  int compares = 0;
  always #4 clk = ~clk;
  pcc_host host (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
  pcc_top uut (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .int_pending(ev[0]), .addr_par_err(ev[1]),
    .data_par_err(ev[2]), .mem_hit(ev[3]), .io_hit(ev[4]),
    .palette_wr(ev[5]), .init_req(ev[6]), .int_o(pins[8]),
    .int_oe(pins[7]), .serr_o(pins[6]), .serr_oe(pins[5]),
    .perr_o(pins[4]), .perr_oe(pins[3]), .claim(pins[2]),
    .snoop_capture(pins[1]), .init_grant_req(pins[0]),
    .cmd_word(cmd_word));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [15:0] g, input logic [15:0] e);
    chk(g, e);
  endtask
  task automatic cmp_cmd(input logic [15:0] g, input logic [15:0] e);
    chk(g, e);
  endtask
  task automatic cmp_pin(input logic [8:0] g, input logic [8:0] e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  // Model keeps only writable bits of the addressed word
  task automatic wr(input logic [7:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    logic [15:0] bm;
    bm = {{8{be[1]}}, {8{be[0]}}};
    if (a == CMD_OFFSET) m = (m & ~bm) | (d & bm & CMD_WMASK);
    wq.push_back(m);
    host.acc(1'b1, a, be, d);
  endtask
  task automatic rd(input logic [7:0] a);
    rq.push_back(a == CMD_OFFSET ? m : 16'h0000);
    host.acc(1'b0, a, 2'h3, 16'h0000);
  endtask
  // Random card events; open-drain data lines must stay low
  task automatic event_cycle();
    logic [8:0] e;
    seed = xs(seed);
    ev = seed[6:0];
    ev_v = 1'b1;
    e = 9'h000;
    e[7] = ev[0] & !m[BIT_INTOFF];
    e[5] = ev[1] & m[BIT_SYSERR] & m[BIT_PARITY];
    e[3] = ev[2] & m[BIT_PARITY];
    e[1] = ev[5] & m[BIT_SNOOP];
    e[2] = ((ev[3] & m[BIT_MEM]) | (ev[4] & m[BIT_IO])) & !e[1];
    e[0] = ev[6] & m[BIT_INIT];
    pq.push_back(e);
    @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Results one cycle after the request, checked mid-cycle
  always @(posedge clk) begin
    ev_v_q <= ev_v;
    rd_q <= cfg_rd;
    wr_q <= cfg_wr;
  end
  always @(negedge clk) begin
    if (wr_q) cmp_cmd(cmd_word, wq.pop_front());
    if (rd_q) cmp_rd(cfg_rdata, rq.pop_front());
    if (ev_v_q) cmp_pin(pins, pq.pop_front());
  end
  // Main sequence: random writes, read-back, event bursts, reset
  initial begin
    m = 16'h0000;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(CMD_OFFSET);
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      wr(seed[8] ? CMD_OFFSET : seed[31:24], seed[10:9],
         seed[31:16]);
      rd(CMD_OFFSET);
      rd(seed[23:16]);
      host.idle();
      repeat (10) event_cycle();
      ev_v = 1'b0;
    end
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    m = 16'h0000;
    rd(CMD_OFFSET);
    host.idle();
    repeat (2) @(posedge clk);
    conclude();
  end
  // Watchdog well beyond the expected run
  initial begin
    #(8 * 5000);
    n_mismatch++;
    conclude();
  end
endmodule // tb
